// >>> rtl/eeprom_bus_pkg.sv
// Purpose: Shared constants and types for the two-wire slave bus-condition layer
// Assumes: sys_clk period of 4 ns
// Notes: Times are kept in their own unit; cycle counts derive from them
package eeprom_bus_pkg;

  // System clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Longest spike the line filters must swallow
  localparam int unsigned SPIKE_NS = 50;
  // Least data hold after the clock falls while transmitting
  localparam int unsigned HOLD_NS = 300;
  // Longest self-timed write cycle
  localparam int unsigned WRITE_CYCLE_MS = 5;

  // Least time rounded up to whole cycles; a spike of SPIKE_NS must not pass
  localparam int unsigned SPIKE_CYC = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int unsigned HOLD_CYC = (HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Longest time rounded down
  localparam longint unsigned WRITE_CYCLE_CYC =
    (64'(WRITE_CYCLE_MS) * 64'd1_000_000_000) / 64'(CLK_PERIOD_PS);

  // Bytes kept from a write burst
  localparam int unsigned PAGE_DEPTH = 16;
  // Entries of the receive buffer
  localparam int unsigned RX_DEPTH = 2;

  // Bit positions within a byte
  localparam int unsigned BYTE_MSB = 7;
  localparam int unsigned RW_BIT = 0;
  // Rising clock edges per byte, and the acknowledge edge
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;

  // Reset values
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic LINE_IDLE = 1'b1;

  // The two bus lines, travelling together
  typedef struct packed {
    logic scl;
    logic sda;
  } line_s;

  localparam line_s LINES_IDLE = '{scl: LINE_IDLE, sda: LINE_IDLE};

endpackage : eeprom_bus_pkg

// >>> rtl/byte_buffer.sv
// Purpose: Small FIFO with valid and ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes: Full and empty are exact; in_ready drops when every entry holds a word
`timescale 1ns/10ps
`default_nettype none
module byte_buffer
  import eeprom_bus_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = RX_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;

  // Handshake decode
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (count != CW'(DEPTH));
  assign out_data = mem[rd_ptr];

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : wrap_inc

  // Storage and pointers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wrap_inc(wr_ptr);
      end
      if (pop)
        rd_ptr <= wrap_inc(rd_ptr);
      count <= count + CW'(push) - CW'(pop);
      out_valid <= (count + CW'(push) - CW'(pop)) != '0;
    end
  end

endmodule : byte_buffer
`default_nettype wire

// >>> rtl/eeprom_bus_slave.sv
// Purpose: Slave-side bus conditions, byte transfer and acknowledge of a serial memory
// Assumes: Bus lines arrive from pins; sda is open-drain, driven low only
// Notes: Addressing is left to the user side through ack_enable
// Operation
// R1: Master clocks bus; we only respond
// R2: Master's read/write bit picks our role
// R3: Master starts transfers only on idle bus
// R4: Both lines high means bus idle
// R5: Data falls while clock high: START
// R6: Data rises while clock high: STOP
// R7: Data change under high clock is condition
// R8: One bit per clock, sampled on rise
// R9: Keep last sixteen written bytes, FIFO order
// R10: Acknowledge every byte we receive; we refuse when ack_enable is low or the receive buffer is full
// R11: Master gives ninth clock for acknowledge
// R12: No acknowledge during programming cycle
// R13: Acknowledge low across whole high period
// R14: Master withholds acknowledge after last byte
// R15: On read no-acknowledge, release data line
// R16: Hold output 300 ns after clock falls
// R17: Write cycle ends within 5 ms
// R18: Swallow spikes up to 50 ns
// R19: Synchronise lines, detect on clean copies
// R20: Write STOP starts cycle, refuse acknowledges
`timescale 1ns/10ps
`default_nettype none
module eeprom_bus_slave
  import eeprom_bus_pkg::*;
#(
  parameter int unsigned FILTER_CYC = SPIKE_CYC,
  parameter int unsigned HOLD_DELAY_CYC = HOLD_CYC,
  parameter longint unsigned WRITE_CYC = WRITE_CYCLE_CYC,
  parameter int unsigned DEPTH = PAGE_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic ack_enable,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic bus_active,
  output logic start_pulse,
  output logic stop_pulse,
  output logic read_mode,
  output logic write_busy,
  output logic [$clog2(DEPTH+1)-1:0] page_count,
  input wire logic [$clog2(DEPTH)-1:0] page_rd_idx,
  output logic [7:0] page_rd_data
);

  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_SEND} bus_state_e;

  localparam int unsigned FW = $clog2(FILTER_CYC + 1);
  localparam int unsigned HW = $clog2(HOLD_DELAY_CYC + 1);
  localparam int unsigned WW = $clog2(WRITE_CYC + 1);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned NW = $clog2(DEPTH + 1);

  line_s sync1;
  line_s sync2;
  line_s clean;
  line_s clean_d;
  logic [FW-1:0] flt_cnt [2];
  bus_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic first_byte;
  logic ack_ok;
  logic master_ack;
  logic data_seen;
  logic pend_oe;
  logic [HW-1:0] hold_cnt;
  logic [WW-1:0] wc_cnt;
  logic [7:0] page [DEPTH];
  logic [PW-1:0] page_wr;
  logic [7:0] rx_byte;
  logic rx_push;
  logic buf_ready;
  logic [7:0] buf_data;
  logic buf_valid;

  // Edge and condition decode on the filtered lines
  wire scl_rise = clean.scl & ~clean_d.scl;
  wire scl_fall = ~clean.scl & clean_d.scl;
  wire start_cond = clean.scl & clean_d.scl & clean_d.sda & ~clean.sda;
  wire stop_cond = clean.scl & clean_d.scl & ~clean_d.sda & clean.sda;
  wire bus_idle = clean.scl & clean.sda;
  wire [7:0] next_shift = {shift[BYTE_MSB-1:0], clean.sda};
  wire byte_done = scl_rise & (state == ST_RECV) & (bit_cnt == BITS_PER_BYTE - 4'h1);
  wire next_ack_ok = ~write_busy & ack_enable & buf_ready;
  wire write_cmd = ~read_mode & data_seen;
  wire [7:0] next_tx = tx_valid ? tx_data : IDLE_BYTE;
  wire port_take = ~rx_valid | rx_ready;

  // Two flip-flop synchroniser on both pins
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1 <= LINES_IDLE;
      sync2 <= LINES_IDLE;
    end
    else
    begin
      sync1 <= '{scl: scl_in, sda: sda_in}; // R19
      sync2 <= sync1;
    end
  end

  // Spike filter: a level passes only after FILTER_CYC stable cycles
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      clean <= LINES_IDLE;
      clean_d <= LINES_IDLE;
      flt_cnt[0] <= '0;
      flt_cnt[1] <= '0;
    end
    else
    begin
      clean_d <= clean;
      for (int i = 0; i < 2; i++)
      begin
        if (sync2[i] == clean[i])
          flt_cnt[i] <= '0; // R18
        else if (flt_cnt[i] == FW'(FILTER_CYC - 1))
        begin
          clean[i] <= sync2[i]; // R18 R19
          flt_cnt[i] <= '0;
        end
        else
          flt_cnt[i] <= flt_cnt[i] + 1'b1;
      end
    end
  end

  // Byte engine: bit count, role and acknowledge decisions
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      shift <= IDLE_BYTE;
      first_byte <= 1'b0;
      ack_ok <= 1'b0;
      master_ack <= 1'b0;
      data_seen <= 1'b0;
      read_mode <= 1'b0;
      pend_oe <= 1'b0;
      tx_ready <= 1'b0;
      rx_push <= 1'b0;
      rx_byte <= '0;
    end
    else
    begin
      tx_ready <= 1'b0;
      rx_push <= 1'b0;
      if (start_cond)
      begin
        state <= ST_RECV; // R5 R7
        bit_cnt <= '0;
        first_byte <= 1'b1;
        data_seen <= 1'b0;
        read_mode <= 1'b0;
        ack_ok <= 1'b0;
        pend_oe <= 1'b0;
      end
      else if (stop_cond)
      begin
        state <= ST_IDLE; // R6 R7
        pend_oe <= 1'b0;
      end
      else if (state == ST_RECV)
      begin
        if (scl_rise && bit_cnt < BITS_PER_BYTE)
        begin
          shift <= next_shift; // R8
          bit_cnt <= bit_cnt + 4'h1;
        end
        else if (scl_rise)
          bit_cnt <= ACK_SLOT; // R11
        if (byte_done)
        begin
          ack_ok <= next_ack_ok; // R10 R12 R20
          rx_push <= next_ack_ok;
          rx_byte <= next_shift;
          if (first_byte)
            read_mode <= next_shift[RW_BIT]; // R2
          else if (next_ack_ok)
            data_seen <= 1'b1;
        end
        if (scl_fall && bit_cnt == BITS_PER_BYTE)
          pend_oe <= ack_ok; // R13
        else if (scl_fall && bit_cnt == ACK_SLOT)
        begin
          bit_cnt <= '0;
          first_byte <= 1'b0;
          if (read_mode && ack_ok)
          begin
            state <= ST_SEND; // R2
            shift <= next_tx;
            tx_ready <= tx_valid;
            pend_oe <= ~next_tx[BYTE_MSB];
          end
          else
            pend_oe <= 1'b0;
        end
      end
      else if (state == ST_SEND)
      begin
        if (scl_rise && bit_cnt == BITS_PER_BYTE)
        begin
          master_ack <= ~clean.sda; // R14
          bit_cnt <= ACK_SLOT;
        end
        else if (scl_rise)
          bit_cnt <= bit_cnt + 4'h1; // R8
        if (scl_fall && bit_cnt < BITS_PER_BYTE)
        begin
          shift <= {shift[BYTE_MSB-1:0], 1'b1};
          pend_oe <= ~shift[BYTE_MSB-1]; // R8
        end
        else if (scl_fall && bit_cnt == BITS_PER_BYTE)
          pend_oe <= 1'b0;
        else if (scl_fall && bit_cnt == ACK_SLOT)
        begin
          bit_cnt <= '0;
          if (master_ack)
          begin
            shift <= next_tx;
            tx_ready <= tx_valid;
            pend_oe <= ~next_tx[BYTE_MSB];
          end
          else
          begin
            state <= ST_IDLE; // R15
            pend_oe <= 1'b0;
          end
        end
      end
    end
  end

  // Output delay: data changes after a clock fall wait HOLD_DELAY_CYC; START and STOP release the line at once
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      hold_cnt <= '0;
    end
    else
    begin
      sda_out <= 1'b0;
      if (start_cond || stop_cond)
      begin
        sda_oe <= 1'b0; // R1
        hold_cnt <= '0;
      end
      else if (scl_fall && state != ST_IDLE)
        hold_cnt <= HW'(HOLD_DELAY_CYC); // R16
      else if (hold_cnt == HW'(1))
      begin
        sda_oe <= pend_oe; // R16
        hold_cnt <= '0;
      end
      else if (hold_cnt != '0)
        hold_cnt <= hold_cnt - 1'b1;
      else if (state == ST_IDLE)
        sda_oe <= 1'b0; // R15
    end
  end

  // Self-timed write cycle, started by the STOP of a write command
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wc_cnt <= '0;
      write_busy <= 1'b0;
    end
    else if (stop_cond && write_cmd && !write_busy)
    begin
      wc_cnt <= WW'(WRITE_CYC - 1); // R20
      write_busy <= 1'b1;
    end
    else if (write_busy)
    begin
      wc_cnt <= wc_cnt - 1'b1;
      if (wc_cnt == '0)
        write_busy <= 1'b0; // R17
    end
  end

  // Burst store: the newest DEPTH bytes overwrite the oldest
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      page_wr <= '0;
      page_count <= '0;
      page_rd_data <= '0;
    end
    else
    begin
      page_rd_data <= page[page_rd_idx];
      if (start_cond)
      begin
        page_wr <= '0;
        page_count <= '0;
      end
      else if (byte_done && next_ack_ok && !first_byte && !read_mode)
      begin
        page[page_wr] <= next_shift; // R9
        page_wr <= (page_wr == PW'(DEPTH - 1)) ? '0 : page_wr + 1'b1;
        if (page_count != NW'(DEPTH))
          page_count <= page_count + 1'b1;
      end
    end
  end

  // Bus status flags
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_active <= 1'b0;
      start_pulse <= 1'b0;
      stop_pulse <= 1'b0;
    end
    else
    begin
      start_pulse <= start_cond;
      stop_pulse <= stop_cond;
      if (start_cond)
        bus_active <= 1'b1;
      else if (stop_cond || (bus_idle && state == ST_IDLE))
        bus_active <= 1'b0; // R4
    end
  end

  // Received bytes leave through a two-entry buffer
  byte_buffer #(
    .WIDTH(8),
    .DEPTH(RX_DEPTH)
  ) rx_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(rx_push),
    .in_data(rx_byte),
    .in_ready(buf_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(port_take)
  );

  // Buffer head registered onto the ports
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_valid <= 1'b0;
      rx_data <= '0;
    end
    else
    begin
      rx_valid <= buf_valid | (rx_valid & ~rx_ready);
      if (buf_valid && port_take)
        rx_data <= buf_data; // Held until the user takes it
    end
  end

endmodule : eeprom_bus_slave
`default_nettype wire

// >>> sim/slave_monitor.sv
// Purpose: Port checks on the bus slave
// Assumes: One clock domain, reset active low
// Notes: Bound to the slave below
`timescale 1ns/10ps
`default_nettype none
module slave_monitor
  import eeprom_bus_pkg::*;
#(
  parameter longint unsigned WRITE_CYC = WRITE_CYCLE_CYC,
  parameter int unsigned DEPTH = PAGE_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic bus_active,
  input wire logic start_pulse,
  input wire logic stop_pulse,
  input wire logic write_busy,
  input wire logic [$clog2(DEPTH+1)-1:0] page_count
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  longint unsigned busy_cnt;
  // Length of the running write cycle
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      busy_cnt <= 0;
    else
      busy_cnt <= write_busy ? busy_cnt + 1 : 0;
  property p_busy_noack;
    write_busy |-> !sda_oe;
  endproperty
  a_busy_noack: assert property (p_busy_noack) else $error("ack during write cycle");
  property p_busy_cause;
    $rose(write_busy) |-> stop_pulse;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("write cycle without stop");
  property p_busy_len;
    busy_cnt <= WRITE_CYC;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle too long");
  property p_start_act;
    start_pulse |-> ##[0:1] bus_active;
  endproperty
  a_start_act: assert property (p_start_act) else $error("start not seen");
  property p_stop_idle;
    stop_pulse |-> ##[0:1] !bus_active;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop left bus active");
  property p_drive_low;
    $rose(sda_oe) |-> !scl_in;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("drive began in clock high");
  property p_hold;
    $fell(scl_in) |=> $stable(sda_oe) [*5];
  endproperty
  a_hold: assert property (p_hold) else $error("data hold too short");
  property p_tx_pulse;
    tx_ready |-> $past(tx_valid) ##1 !tx_ready;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("bad send handshake");
  property p_rx_hold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("received word lost");
  property p_page_max;
    page_count <= DEPTH;
  endproperty
  a_page_max: assert property (p_page_max) else $error("store count too high");
endmodule : slave_monitor
bind eeprom_bus_slave slave_monitor #(.WRITE_CYC(WRITE_CYC), .DEPTH(DEPTH)) slave_monitor_i (
  .sys_clk(sys_clk), .resetn(resetn), .scl_in(scl_in), .sda_oe(sda_oe), .rx_data(rx_data),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .bus_active(bus_active), .start_pulse(start_pulse), .stop_pulse(stop_pulse),
  .write_busy(write_busy), .page_count(page_count));
`default_nettype wire

// >>> sim/bus_master.sv
// Purpose: Bus master model driving clock and data
// Assumes: 48 ns clock pulse, 32 ns low and 16 ns high
// Notes: Lines move 1 ns after a system edge; clock rests high
`timescale 1ns/10ps
`default_nettype none
module bus_master
(
  input wire logic sys_clk,
  input wire logic sda,
  output var logic scl,
  output var logic sda_m
);
  // Idle bus at time zero
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Wait whole cycles, then settle
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wt
  // One pulse; data moves only while low
  task automatic bit_x(input logic b, output logic s);
    scl = 1'b0;
    wt(4);
    sda_m = b;
    wt(4);
    scl = 1'b1;
    wt(2);
    s = sda;
    wt(2);
  endtask : bit_x
  // Condition from a high clock
  task automatic start_c();
    scl = 1'b0;
    wt(4);
    sda_m = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_m = 1'b0;
    wt(6);
  endtask : start_c
  task automatic stop_c();
    scl = 1'b0;
    wt(4);
    sda_m = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_m = 1'b1;
    wt(8);
  endtask : stop_c
  // Byte out, then the extra pulse for the answer
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask : put
  // Byte in, then our answer
  task automatic get(input logic nak, output logic [7:0] b);
    logic s;
    for (int i = 0; i < 8; i++)
    begin
      bit_x(1'b1, s);
      b = {b[6:0], s};
    end
    bit_x(nak, s);
  endtask : get
  // Deliberate one-cycle spike on one line
  task automatic glitch(input logic on_clk);
    wt(1);
    if (on_clk)
      scl = 1'b0;
    else
      sda_m = 1'b0;
    wt(1);
    scl = 1'b1;
    sda_m = 1'b1;
    wt(20);
  endtask : glitch
endmodule : bus_master
`default_nettype wire

// >>> sim/serial_eeprom_bus_conditions_test.sv
// Purpose: Self-checking bench for the bus slave
// Assumes: Short filter, hold and write counts
// Notes: Random data from a fixed-seed shift register
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_bus_conditions_test;
  import eeprom_bus_pkg::*;
  logic sys_clk, resetn, ack_enable, rx_ready, stall = 1'b0, took;
  logic tx_valid, sda_oe, sda_out, rx_valid, tx_ready, bus_active, start_pulse;
  logic stop_pulse, read_mode, write_busy, a, scl, sda_m;
  logic [7:0] rx_data, tx_data, b, pg_data, pg [18];
  logic [4:0] page_count;
  logic [3:0] page_rd_idx;
  logic [31:0] rs = 32'h0000_38ad;
  logic [7:0] rx_q [$], eq [$], tq [$];
  int miscompares = 0, tests_run = 0, starts = 0, stops = 0;
  wire sda = sda_m & ~sda_oe;
  eeprom_bus_slave #(.FILTER_CYC(2), .HOLD_DELAY_CYC(1), .WRITE_CYC(200)) eeprom_bus_slave_i (
    .sys_clk(sys_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .ack_enable(ack_enable), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .bus_active(bus_active), .start_pulse(start_pulse), .stop_pulse(stop_pulse),
    .read_mode(read_mode), .write_busy(write_busy), .page_count(page_count),
    .page_rd_idx(page_rd_idx), .page_rd_data(pg_data));
  bus_master bus_master_i (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  always #2 sys_clk = ~sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // Random receive stalls, pulse counts, word capture
  always @(posedge sys_clk)
  begin
    starts += (start_pulse === 1'b1);
    stops += (stop_pulse === 1'b1);
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      rx_q.push_back(rx_data);
    if (tx_ready === 1'b1)
      tq.push_back(tx_data);
    took = (tx_ready === 1'b1);
    #1;
    rs = lfsr(rs);
    rx_ready = stall ? 1'b0 : rs[3];
    if (took)
      tx_data = rs[15:8];
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] d, input logic ea);
    bus_master_i.put(d, a);
    chk(a, ea);
    if (ea)
      eq.push_back(d);
  endtask : wr
  task automatic cmp_rx(input string n);
    bus_master_i.wt(40);
    chk(rx_q.size(), eq.size());
    foreach (eq[i])
      chk(rx_q[i], eq[i]);
    rx_q.delete();
    eq.delete();
    $display("test %s done", n);
  endtask : cmp_rx
  task automatic wait_idle();
    for (int n = 0; n < 220 && write_busy !== 1'b0; n++)
      bus_master_i.wt(1);
    chk(write_busy, 1'b0);
  endtask : wait_idle
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Watchdog on a hung run
  initial
  begin
    #200_000;
    miscompares++;
    wrap_up();
  end
  initial
  begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    ack_enable = 1'b1;
    rx_ready = 1'b0;
    tx_valid = 1'b1;
    tx_data = 8'h5a;
    page_rd_idx = 4'h0;
    bus_master_i.wt(3);
    resetn = 1'b1;
    bus_master_i.wt(20);
    for (int i = 0; i < 4; i++)
      bus_master_i.glitch(i[0]);
    chk(starts, 0);
    chk(bus_active, 1'b0);
    bus_master_i.start_c();
    chk(bus_active, 1'b1);
    wr(8'ha0, 1'b1);
    for (int k = 0; k < 18; k++)
    begin
      rs = lfsr(rs);
      pg[k] = rs[7:0];
      wr(pg[k], 1'b1);
    end
    bus_master_i.stop_c();
    chk({starts[7:0], stops[7:0]}, 16'h0101);
    chk(write_busy, 1'b1);
    chk(page_count, 5'h10);
    for (int k = 2; k < 18; k++)
    begin
      page_rd_idx = k[3:0];
      bus_master_i.wt(2);
      chk(pg_data, pg[k]);
    end
    cmp_rx("write");
    bus_master_i.start_c();
    wr(8'ha0, 1'b0);
    bus_master_i.stop_c();
    wait_idle();
    bus_master_i.start_c();
    wr(8'ha1, 1'b1);
    chk(read_mode, 1'b1);
    bus_master_i.get(1'b0, b);
    chk(b, tq.pop_front());
    tx_valid = 1'b0;
    bus_master_i.get(1'b0, b);
    chk(b, IDLE_BYTE);
    tx_valid = 1'b1;
    bus_master_i.get(1'b1, b);
    chk(b, tq.pop_front());
    bus_master_i.wt(2);
    chk(sda_oe, 1'b0);
    bus_master_i.stop_c();
    chk(write_busy, 1'b0);
    cmp_rx("read");
    stall = 1'b1;
    bus_master_i.start_c();
    wr(8'ha0, 1'b1);
    wr(rs[7:0], 1'b1);
    wr(rs[15:8], 1'b1);
    wr(rs[31:24], 1'b0);
    stall = 1'b0;
    bus_master_i.wt(30);
    ack_enable = 1'b0;
    wr(rs[23:16], 1'b0);
    ack_enable = 1'b1;
    bus_master_i.stop_c();
    chk(write_busy, 1'b1);
    wait_idle();
    cmp_rx("buffer");
    wrap_up();
  end
endmodule : serial_eeprom_bus_conditions_test
`default_nettype wire
